// ===== logic/rtc_trim_alarm_pkg.sv
// Constants and carriers shared by the alarm and trim block.
// Assumes BCD time fields from the calendar counters on the system clock.
package rtc_trim_alarm_pkg;

	// ----------------------------------------
	// Register addresses (4-bit pointer)
	// ----------------------------------------
	localparam logic [3:0] ADDR_TRIM = 4'h7;
	localparam logic [3:0] ADDR_WEEKLY_ALARM_MINUTE = 4'h8;
	localparam logic [3:0] ADDR_WEEKLY_ALARM_HOUR = 4'h9;
	localparam logic [3:0] ADDR_WEEKLY_ALARM_DAY_MASK = 4'hA;
	localparam logic [3:0] ADDR_DAILY_ALARM_MINUTE = 4'hB;
	localparam logic [3:0] ADDR_DAILY_ALARM_HOUR = 4'hC;

	// ----------------------------------------
	// Field widths and positions
	// ----------------------------------------
	localparam int MINUTE_W = 7;
	localparam int HOUR_W = 6;
	localparam int DAY_MASK_W = 7;
	localparam int TRIM_DIR_BIT = 6;
	localparam int TRIM_LOCK_BIT = 7;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] TRIM_RESET = 8'h00;
	localparam logic [6:0] MINUTE_RESET = 7'h00;
	localparam logic [5:0] HOUR_RESET = 6'h00;
	localparam logic [6:0] DAY_MASK_RESET = 7'h00;

	// ----------------------------------------
	// Timing counts in crystal pulses and in seconds
	// ----------------------------------------
	localparam logic [15:0] PULSES_PER_SECOND = 16'h8000;
	localparam int TRIM_STEP_PULSES = 2;
	localparam int TRIM_INTERVAL_SECONDS = 20;
	localparam logic [6:0] TRIM_SECOND_A = 7'h00;
	localparam logic [6:0] TRIM_SECOND_B = 7'h20;
	localparam logic [6:0] TRIM_SECOND_C = 7'h40;

	// Current time as seen from the calendar counters
	typedef struct packed {
		logic [6:0] second;
		logic [6:0] minute;
		logic [5:0] hour;
		logic [2:0] weekday;
	} time_now_t;

	// Register access strobe with its data
	typedef struct packed {
		logic wr_en;
		logic [3:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

endpackage

// ===== logic/rtc_trim_alarm.sv
// Alarm comparators, their registers and the second-length trim unit.
// Assumes the serial port decodes frames into reg_req_t strobes on the
// system clock, and that the crystal pulse arrives asynchronously.
`timescale 1ns/1ps

module rtc_trim_alarm (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_xtal_pulse,
	input wire logic i_osc_stop_flag,
	input wire rtc_trim_alarm_pkg::time_now_t i_time_now,
	input wire rtc_trim_alarm_pkg::reg_req_t i_reg_req,
	output logic [7:0] o_reg_rdata,
	output logic o_second_tick,
	output logic o_weekly_alarm_match,
	output logic o_daily_alarm_match
);
	import rtc_trim_alarm_pkg::*;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------

	// Signed pulse offset for a trim setting; the result is added
	// to the nominal count, never to the oscillator itself
	function automatic logic signed [8:0] trim_offset(input logic [7:0] trim);
		logic [5:0] mag;
		logic signed [8:0] off;
		mag = trim[5:0];
		off = 9'sh000;
		if (trim[TRIM_LOCK_BIT] || mag[5:1] == 5'h00) begin
			off = 9'sh000;
		end else if (!trim[TRIM_DIR_BIT]) begin
			off = 9'(({3'h0, mag} - 9'h001) * TRIM_STEP_PULSES);
		end else begin
			off = -9'(({3'h0, ~mag} + 9'h001) * TRIM_STEP_PULSES);
		end
		return off;
	endfunction

	// Hit when the second counter sits on 00, 20 or 40
	function automatic logic trim_second(input logic [6:0] sec);
		return sec == TRIM_SECOND_A || sec == TRIM_SECOND_B || sec == TRIM_SECOND_C;
	endfunction

	// ----------------------------------------
	// Crystal pulse synchroniser
	// ----------------------------------------
	logic xtal_meta;
	logic xtal_sync;
	logic xtal_prev;
	logic stop_meta;
	logic stop_sync;

	// Two flops before any logic looks at the pin
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			xtal_meta <= 1'b0;
			xtal_sync <= 1'b0;
			xtal_prev <= 1'b0;
		end else begin
			xtal_meta <= i_xtal_pulse;
			xtal_sync <= xtal_meta;
			xtal_prev <= xtal_sync;
		end
	end

	// Stop flag comes from the supply monitor, so sync it too
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			stop_meta <= 1'b0;
			stop_sync <= 1'b0;
		end else begin
			stop_meta <= i_osc_stop_flag;
			stop_sync <= stop_meta;
		end
	end

	logic xtal_rise;
	assign xtal_rise = xtal_sync && !xtal_prev;

	// ----------------------------------------
	// Register bank
	// ----------------------------------------
	logic [7:0] trim;
	logic [6:0] weekly_alarm_minute;
	logic [5:0] weekly_alarm_hour;
	logic [6:0] weekly_alarm_day_mask;
	logic [6:0] daily_alarm_minute;
	logic [5:0] daily_alarm_hour;

	logic wr_trim;
	assign wr_trim = i_reg_req.wr_en && i_reg_req.addr == ADDR_TRIM;

	// Trim register; stop flag forces it clear so a dead
	// oscillator never leaves a stale correction behind
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			trim <= TRIM_RESET;
		end else if (stop_sync) begin
			trim <= TRIM_RESET;
		end else if (wr_trim) begin
			trim <= i_reg_req.wdata;
		end
	end

	// Alarm registers keep only their used bits; contents after a
	// stop are whatever was there, which software must treat as junk
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			weekly_alarm_minute <= MINUTE_RESET;
			weekly_alarm_hour <= HOUR_RESET;
			weekly_alarm_day_mask <= DAY_MASK_RESET;
			daily_alarm_minute <= MINUTE_RESET;
			daily_alarm_hour <= HOUR_RESET;
		end else if (i_reg_req.wr_en) begin
			case (i_reg_req.addr)
				ADDR_WEEKLY_ALARM_MINUTE: begin
					weekly_alarm_minute <= i_reg_req.wdata[MINUTE_W-1:0];
				end
				ADDR_WEEKLY_ALARM_HOUR: begin
					weekly_alarm_hour <= i_reg_req.wdata[HOUR_W-1:0];
				end
				ADDR_WEEKLY_ALARM_DAY_MASK: begin
					weekly_alarm_day_mask <= i_reg_req.wdata[DAY_MASK_W-1:0];
				end
				ADDR_DAILY_ALARM_MINUTE: begin
					daily_alarm_minute <= i_reg_req.wdata[MINUTE_W-1:0];
				end
				ADDR_DAILY_ALARM_HOUR: begin
					daily_alarm_hour <= i_reg_req.wdata[HOUR_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Read mux, registered; unused bits and addresses return zero
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_reg_rdata <= 8'h00;
		end else begin
			case (i_reg_req.addr)
				ADDR_TRIM: o_reg_rdata <= trim;
				ADDR_WEEKLY_ALARM_MINUTE: o_reg_rdata <= {1'b0, weekly_alarm_minute};
				ADDR_WEEKLY_ALARM_HOUR: o_reg_rdata <= {2'b00, weekly_alarm_hour};
				ADDR_WEEKLY_ALARM_DAY_MASK: o_reg_rdata <= {1'b0, weekly_alarm_day_mask};
				ADDR_DAILY_ALARM_MINUTE: o_reg_rdata <= {1'b0, daily_alarm_minute};
				ADDR_DAILY_ALARM_HOUR: o_reg_rdata <= {2'b00, daily_alarm_hour};
				default: o_reg_rdata <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Second counter with trim
	// ----------------------------------------
	logic [15:0] pulse_count;
	logic [15:0] second_target;
	logic trim_written;
	logic second_end;

	// Remember a trim write inside the running second, so the
	// boundary it falls on runs untrimmed; the write wins the race
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			trim_written <= 1'b0;
		end else if (wr_trim) begin
			trim_written <= 1'b1;
		end else if (second_end) begin
			trim_written <= 1'b0;
		end
	end

	// Target length of the running second: only seconds 00, 20, 40
	// are touched, which spreads one step over a 20 s interval
	always_comb begin
		second_target = PULSES_PER_SECOND;
		if (trim_second(i_time_now.second) && !trim_written && !wr_trim) begin
			second_target = 16'(PULSES_PER_SECOND + 16'(trim_offset(trim)));
		end
	end

	assign second_end = xtal_rise && (pulse_count + 16'h0001 >= second_target);

	// Only the count of pulses changes; the crystal runs untouched
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pulse_count <= 16'h0000;
		end else if (second_end) begin
			pulse_count <= 16'h0000;
		end else if (xtal_rise) begin
			pulse_count <= pulse_count + 16'h0001;
		end
	end

	// One-cycle tick that advances the calendar counters
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_second_tick <= 1'b0;
		end else begin
			o_second_tick <= second_end;
		end
	end

	// ----------------------------------------
	// Alarm comparators
	// ----------------------------------------
	logic weekday_enabled;

	// Weekday 7 is not a valid day, so it never selects a mask bit
	always_comb begin
		weekday_enabled = 1'b0;
		if (i_time_now.weekday != 3'h7) begin
			weekday_enabled = weekly_alarm_day_mask[i_time_now.weekday];
		end
	end

	// Raw BCD compare; 12-hour codes (12 for midnight, 32 for noon)
	// match only because the counters use the same encoding
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_weekly_alarm_match <= 1'b0;
			o_daily_alarm_match <= 1'b0;
		end else begin
			o_weekly_alarm_match <= weekday_enabled
				&& i_time_now.minute == weekly_alarm_minute
				&& i_time_now.hour == weekly_alarm_hour;
			o_daily_alarm_match <= i_time_now.minute == daily_alarm_minute
				&& i_time_now.hour == daily_alarm_hour;
		end
	end

endmodule

// ===== verif/rtc_host_model.sv
// Host model: register strobes as the serial port hands them over.
// Assumes one caller at a time on the block's system clock.
`timescale 1ns/1ps
module rtc_host_model (
	input wire logic i_sys_clk,
	input wire logic [7:0] i_reg_rdata,
	output rtc_trim_alarm_pkg::reg_req_t o_reg_req
);
	import rtc_trim_alarm_pkg::*;
	// ----
	// Access tasks
	// ----
	initial o_reg_req = '0;
	// One-cycle strobe; host never sets the trim lock bit
	task automatic wr(input logic [3:0] ad, input logic [7:0] d);
		@(posedge i_sys_clk);
		o_reg_req <= '{1'b1, ad, (ad == ADDR_TRIM) ? (d & 8'h7F) : d};
		@(posedge i_sys_clk);
		o_reg_req.wr_en <= 1'b0;
	endtask
	// Address driven one edge ahead of the sampled edge, read mux is registered
	task automatic rd(input logic [3:0] ad, output logic [7:0] d);
		@(posedge i_sys_clk);
		o_reg_req.addr <= ad;
		@(posedge i_sys_clk);
		#1;
		d = i_reg_rdata;
	endtask
endmodule

// ===== verif/rtc_trim_alarm_checker.sv
// Port checker for the alarm and trim block.
// Assumes it is bound into rtc_trim_alarm.
`timescale 1ns/1ps
module rtc_trim_alarm_checker (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_xtal_pulse,
	input wire logic i_osc_stop_flag,
	input wire rtc_trim_alarm_pkg::time_now_t i_time_now,
	input wire rtc_trim_alarm_pkg::reg_req_t i_reg_req,
	input wire logic [7:0] o_reg_rdata,
	input wire logic o_second_tick,
	input wire logic o_weekly_alarm_match,
	input wire logic o_daily_alarm_match
);
	import rtc_trim_alarm_pkg::*;
	// ----
	// Properties
	// ----
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_reset_n);
	// Short alias, the read mux follows it
	wire logic [3:0] a = i_reg_req.addr;
	property p_unm;
		(a < 4'h7 || a > 4'hC) |=> o_reg_rdata == 8'h00;
	endproperty
	a_unm: assert property (p_unm) else $error("unmapped read");
	property p_min;
		(a == 4'h8 || a == 4'hB) |=> !o_reg_rdata[7];
	endproperty
	a_min: assert property (p_min) else $error("minute bit 7");
	property p_hour;
		(a == 4'h9 || a == 4'hC) |=> o_reg_rdata[7:6] == 2'h0;
	endproperty
	a_hour: assert property (p_hour) else $error("hour top bits");
	property p_mask;
		a == 4'hA |=> !o_reg_rdata[7];
	endproperty
	a_mask: assert property (p_mask) else $error("mask bit 7");
	property p_wr;
		(i_reg_req.wr_en && a == 4'h8) ##1 (a == 4'h8 && !i_reg_req.wr_en)
		|=> o_reg_rdata[6:0] == $past(i_reg_req.wdata[6:0], 2);
	endproperty
	a_wr: assert property (p_wr) else $error("minute readback");
	property p_day7;
		i_time_now.weekday == 3'h7 |=> !o_weekly_alarm_match;
	endproperty
	a_day7: assert property (p_day7) else $error("weekday 7 match");
	property p_tick;
		o_second_tick |=> !o_second_tick [*8];
	endproperty
	a_tick: assert property (p_tick) else $error("tick too long");
	property p_stop;
		(i_osc_stop_flag [*5] ##0 a == 4'h7) |=> o_reg_rdata == 8'h00;
	endproperty
	a_stop: assert property (p_stop) else $error("trim not cleared");
	c_tick: cover property (o_second_tick);
	c_wk: cover property (o_weekly_alarm_match);
	c_dy: cover property (o_daily_alarm_match);
endmodule
bind rtc_trim_alarm rtc_trim_alarm_checker u_chk (.i_sys_clk, .i_reset_n, .i_xtal_pulse,
	.i_osc_stop_flag, .i_time_now, .i_reg_req, .o_reg_rdata, .o_second_tick,
	.o_weekly_alarm_match, .o_daily_alarm_match);

// ===== verif/rtc_trim_alarm_tb.sv
// Self-checking bench for the alarm and trim block.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
module rtc_trim_alarm_tb;
	import rtc_trim_alarm_pkg::*;
	// ----
	// Stimulus, model and checks
	// ----
	logic i_sys_clk = 0;
	logic i_reset_n = 0;
	logic xtal = 0;
	logic stop = 0;
	time_now_t now = '0;
	reg_req_t req;
	logic [7:0] rdata, got, v, h;
	logic tick, wk, dy;
	logic [7:0] hrs[4] = '{8'h12, 8'h32, 8'h01, 8'h23};
	int n_fail = 0, num_checks = 0, ticks = 0, seed = 32'h8FEB4E60;
	rtc_trim_alarm DUT (.i_sys_clk, .i_reset_n, .i_xtal_pulse(xtal), .i_osc_stop_flag(stop),
		.i_time_now(now), .i_reg_req(req), .o_reg_rdata(rdata), .o_second_tick(tick),
		.o_weekly_alarm_match(wk), .o_daily_alarm_match(dy));
	rtc_host_model host (.i_sys_clk, .i_reg_rdata(rdata), .o_reg_req(req));
	initial forever #2.5 i_sys_clk = ~i_sys_clk;
	// Tick counter, sampled before the edge lands
	always @(posedge i_sys_clk)
		if (tick === 1'b1)
			ticks++;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic stop_test();
		$display("checks=%0d fails=%0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Readable bits per address; lock bit never set by the host
	function automatic logic [7:0] keep(input logic [3:0] a);
		case (a)
			4'h7, 4'h8, 4'hA, 4'hB: return 8'h7F;
			4'h9, 4'hC: return 8'h3F;
			default: return 8'h00;
		endcase
	endfunction
	// Pulses in one second from trim value, second and write flag
	function automatic int slen(input logic [7:0] t, input logic [6:0] s, input bit w);
		if (w || t[7] || t[5:1] == 0 || !(s inside {7'h00, 7'h20, 7'h40}))
			return 32768;
		return t[6] ? 32768 - (64 - t[5:0]) * 2 : 32768 + (t[5:0] - 1) * 2;
	endfunction
	// Last pulse held back to see the tick land on it exactly
	task automatic run_second(input int n);
		int b;
		b = ticks;
		for (int k = 1; k < n; k++) begin
			@(posedge i_sys_clk) xtal <= 1'b1;
			@(posedge i_sys_clk) xtal <= 1'b0;
		end
		repeat (8) @(posedge i_sys_clk);
		chk(ticks, b);
		@(posedge i_sys_clk) xtal <= 1'b1;
		@(posedge i_sys_clk) xtal <= 1'b0;
		for (int k = 0; k < 10 && ticks == b; k++)
			@(posedge i_sys_clk);
		chk(ticks, b + 1);
		if (ticks == b)
			stop_test();
	endtask
	initial begin
		repeat (3) @(posedge i_sys_clk);
		i_reset_n <= 1'b1;
		for (int a = 0; a < 16; a++) begin
			v = 8'($random(seed));
			host.wr(a[3:0], v);
			host.rd(a[3:0], got);
			chk(got, v & keep(a[3:0]));
		end
		$display("test registers done");
		// Empty mask first, then random masks over all weekday codes
		for (int i = 0; i < 16; i++) begin
			h = hrs[i % 4];
			v = (i == 0) ? 8'h00 : 8'($random(seed)) & 8'h7F;
			host.wr(4'h8, 8'h30);
			host.wr(4'h9, h);
			host.wr(4'hA, v);
			host.wr(4'hB, 8'h30);
			host.wr(4'hC, (i % 3 == 0) ? h : 8'h05);
			@(posedge i_sys_clk) now <= '{7'h00, (i % 5 == 4) ? 7'h31 : 7'h30, h[5:0], 3'(i % 8)};
			repeat (2) @(posedge i_sys_clk);
			#1;
			chk(wk, now.minute == 7'h30 && now.weekday < 7 && v[now.weekday]);
			chk(dy, now.minute == 7'h30 && i % 3 == 0);
		end
		$display("test alarms done");
		@(posedge i_sys_clk) stop <= 1'b1;
		repeat (6) @(posedge i_sys_clk);
		host.rd(4'h7, got);
		chk(got, 8'h00);
		@(posedge i_sys_clk) stop <= 1'b0;
		repeat (4) @(posedge i_sys_clk);
		host.wr(4'h7, 8'h07);
		run_second(slen(8'h07, now.second, 1));
		run_second(slen(8'h07, now.second, 0));
		$display("test trim done");
		stop_test();
	end
endmodule
